/* File: tuma_pkg.sv */
// Purpose: shared constants and types for the tandem transmit master arbiter
// Assumes: one clock domain, 32-bit AXI4-Lite register access
// Notes:   field layouts follow the packed struct member order
package tuma_pkg;

	localparam int         AXI_AW      = 4;
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_STAT    = 4'h4;
	localparam logic [3:0] REG_VPI     = 4'h8;
	localparam logic [3:0] REG_LEN     = 4'hC;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int N_PAIR = 4;
	localparam int N_ADDR = 16;
	localparam int N_PORT = N_PAIR * N_ADDR;

	// cell lengths in bytes
	localparam logic [6:0] LEN_STD8  = 7'h35;
	localparam logic [6:0] LEN_EXT8  = 7'h39;
	localparam logic [6:0] LEN_STD16 = 7'h36;
	localparam logic [6:0] LEN_EXT16 = 7'h3A;

	// translation table depth
	localparam logic [12:0] VPI_UNI = 13'h0100;
	localparam logic [12:0] VPI_NNI = 13'h1000;

	// strap is sampled on the boot count just below this one, which marks booted
	localparam logic [1:0] BOOT_CYC = 2'h3;

	localparam int CTRL_W = 10;
	typedef struct packed {
		logic [4:0] poll_max;
		logic       nni;
		logic       ext_hdr;
		logic       bus16;
		logic       slave;
		logic       tandem;
	} tuma_ctrl_t;

	localparam tuma_ctrl_t CTRL_RST = '{poll_max: 5'h0F, nni: 1'b0,
		ext_hdr: 1'b0, bus16: 1'b0, slave: 1'b0, tandem: 1'b0};

	typedef struct packed {
		logic [4:0] last_addr;
		logic       slave;
		logic       xfer;
		logic       req;
		logic       grant;
		logic       owner;
		logic       primary;
	} tuma_stat_t;

	// transmit pins towards the phys
	typedef struct packed {
		logic [4:0] addr;
		logic       addr_oe;
		logic [3:0] enb_n;
		logic       enb_oe;
	} tuma_utx_t;

	typedef enum logic [2:0] {
		ST_OFF, ST_TAKE, ST_POLL, ST_SEL, ST_XFER, ST_REL
	} tuma_st_t;

endpackage

/* File: tuma_arbiter.sv */
// Purpose: tandem utopia transmit master with bus handover arbitration
// Assumes: peer master and phy pins are asynchronous, synchronised here
// Notes:   one design runs as primary or secondary, chosen by strap
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module tuma_arbiter
(
	// clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// axi4-lite register port
	input  wire logic [tuma_pkg::AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output      logic                          s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output      logic                          s_axi_wready,
	output      logic [1:0]                    s_axi_bresp,
	output      logic                          s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [tuma_pkg::AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output      logic                          s_axi_arready,
	output      logic [31:0]                   s_axi_rdata,
	output      logic [1:0]                    s_axi_rresp,
	output      logic                          s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// utopia transmit pins
	output      tuma_pkg::tuma_utx_t           utx,
	input  wire logic [4:0]                    utx_addr_i,
	input  wire logic [3:0]                    utx_clav_i,
	// tandem peer lines and role strap
	output      logic                          tdm_req_o,
	output      logic                          tdm_grant_o,
	output      logic                          tdm_busy_o,
	input  wire logic                          tdm_req_i,
	input  wire logic                          tdm_grant_i,
	input  wire logic                          tdm_busy_i,
	input  wire logic                          strap_primary_i,
	// cell source side
	input  wire logic [tuma_pkg::N_PORT-1:0]   cell_pend_i,
	output      logic [5:0]                    cell_port_o,
	output      logic                          cell_xfer_o,
	output      logic                          cell_done_o,
	output      logic                          rx_accept_all_o
);

	localparam int SYNC_W = 13;

	tuma_pkg::tuma_ctrl_t                ctrl_q;
	tuma_pkg::tuma_st_t                  st_q;
	tuma_pkg::tuma_st_t                  st_d;
	tuma_pkg::tuma_utx_t                 utx_q;
	logic [SYNC_W-1:0]                   meta_q;
	logic [SYNC_W-1:0]                   sync_q;
	logic [4:0]                          addr_s;
	logic [3:0]                          clav_s;
	logic                                req_s;
	logic                                grant_s;
	logic                                busy_s;
	logic                                strap_s;
	logic [1:0]                          boot_q;
	logic                                primary_q;
	logic                                booted;
	logic                                is_pri;
	logic [tuma_pkg::N_PORT-1:0]         avail_q;
	logic [tuma_pkg::N_PORT-1:0]         elig;
	logic [6:0]                          pick;
	logic [5:0]                          sel_q;
	logic [5:0]                          cnt_q;
	logic [5:0]                          words;
	logic [4:0]                          poll_q;
	logic                                grant_q;
	logic                                req_q;
	logic                                busy_q;
	logic                                busy_prev_q;
	logic [5:0]                          port_q;
	logic                                xfer_q;
	logic                                done_q;
	logic [6:0]                          xfer_run;
	logic [4:0]                          seen_q;
	logic [6:0]                          len;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	function automatic logic [6:0] cell_len(tuma_pkg::tuma_ctrl_t c);
		if (c.bus16)
			return c.ext_hdr ? tuma_pkg::LEN_EXT16 : tuma_pkg::LEN_STD16;
		return c.ext_hdr ? tuma_pkg::LEN_EXT8 : tuma_pkg::LEN_STD8;
	endfunction

	function automatic logic [4:0] next_addr(logic [4:0] a, logic [4:0] mx);
		return (a >= mx) ? 5'h00 : a + 5'h01;
	endfunction

	function automatic logic [6:0] first_set(
		logic [tuma_pkg::N_PORT-1:0] v);
		logic [6:0] r;
		r = '0;
		for (int i = tuma_pkg::N_PORT - 1; i >= 0; i--)
		begin
			if (v[i])
				r = {1'b1, 6'(i)};
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and role strap

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= {utx_addr_i, utx_clav_i, tdm_req_i, tdm_grant_i,
				tdm_busy_i, strap_primary_i};
			sync_q <= meta_q;
		end
	end

	assign {addr_s, clav_s, req_s, grant_s, busy_s, strap_s} = sync_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			boot_q    <= '0;
			primary_q <= 1'b0;
		end
		else
		begin
			if (boot_q != tuma_pkg::BOOT_CYC)
				boot_q <= boot_q + 2'h1;
			if (boot_q == tuma_pkg::BOOT_CYC - 2'h1)
				primary_q <= strap_s;
		end
	end

	assign booted = (boot_q == tuma_pkg::BOOT_CYC);
	assign is_pri = primary_q | ~ctrl_q.tandem;

	////////////////////////////////////////////////////////////////////////
	// clav table, one bit per port

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			avail_q <= '0;
		else
		begin
			if (!addr_s[4] && addr_s <= ctrl_q.poll_max)
			begin
				for (int i = 0; i < tuma_pkg::N_PAIR; i++)
					avail_q[{i[1:0], addr_s[3:0]}] <= clav_s[i];
			end
			if (st_q == tuma_pkg::ST_SEL)
				avail_q[sel_q] <= 1'b0;
		end
	end

	assign elig  = avail_q & cell_pend_i;
	assign pick  = first_set(elig);
	assign len   = cell_len(ctrl_q);
	assign words = ctrl_q.bus16 ? len[6:1] : len[5:0];

	// last real poll address on the bus, whoever drove it;
	// the all-high release address is skipped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			seen_q <= '0;
		else if (!addr_s[4] && addr_s <= ctrl_q.poll_max)
			seen_q <= addr_s;
	end

	////////////////////////////////////////////////////////////////////////
	// bus ownership state machine

	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			tuma_pkg::ST_OFF:
				if (booted && !ctrl_q.slave)
				begin
					if (is_pri ? (!busy_s && !grant_q)
						: (grant_s && !busy_s))
						st_d = tuma_pkg::ST_TAKE;
				end
			tuma_pkg::ST_TAKE:
				st_d = tuma_pkg::ST_POLL;
			tuma_pkg::ST_POLL:
				if (ctrl_q.slave || (is_pri && grant_q))
					st_d = tuma_pkg::ST_REL;
				else if (pick[6])
					st_d = tuma_pkg::ST_SEL;
				else if (!is_pri)
					st_d = tuma_pkg::ST_REL;
			tuma_pkg::ST_SEL:
				st_d = tuma_pkg::ST_XFER;
			tuma_pkg::ST_XFER:
				if (cnt_q == words - 6'h01)
				begin
					if (is_pri)
						st_d = grant_q ? tuma_pkg::ST_REL
							: tuma_pkg::ST_POLL;
					else
						st_d = grant_s ? tuma_pkg::ST_POLL
							: tuma_pkg::ST_REL;
				end
			tuma_pkg::ST_REL:
				st_d = tuma_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_q <= tuma_pkg::ST_OFF;
		else
			st_q <= st_d;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= '0;
		else if (st_q == tuma_pkg::ST_XFER)
			cnt_q <= cnt_q + 6'h01;
		else
			cnt_q <= '0;
	end

	// polling address and selected port
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			poll_q <= '0;
			sel_q  <= '0;
		end
		else
		begin
			// loaded on entry so the first driven address is the resumed one
			if (st_d == tuma_pkg::ST_TAKE)
				poll_q <= next_addr(seen_q, ctrl_q.poll_max);
			else if (st_q == tuma_pkg::ST_TAKE
				|| st_q == tuma_pkg::ST_POLL
				|| st_q == tuma_pkg::ST_XFER)
				poll_q <= next_addr(poll_q, ctrl_q.poll_max);
			if (st_q == tuma_pkg::ST_POLL && st_d == tuma_pkg::ST_SEL)
				sel_q <= pick[5:0];
		end
	end

	// pin drive follows the next state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			utx_q <= '{addr: 5'h1F, addr_oe: 1'b0, enb_n: 4'hF, enb_oe: 1'b0};
		else
		begin
			utx_q.enb_n <= 4'hF;
			utx_q.addr  <= poll_q;
			unique case (st_d)
				tuma_pkg::ST_SEL:
					utx_q.addr <= {1'b0, pick[3:0]};
				tuma_pkg::ST_XFER:
					utx_q.enb_n <= ~(4'h1 << sel_q[5:4]);
				tuma_pkg::ST_REL:
					utx_q.addr <= 5'h1F;
				default:
					utx_q.addr <= poll_q;
			endcase
			utx_q.addr_oe <= !ctrl_q.slave && st_d != tuma_pkg::ST_OFF
				&& st_d != tuma_pkg::ST_TAKE;
			utx_q.enb_oe  <= !ctrl_q.slave && st_d != tuma_pkg::ST_OFF
				&& st_d != tuma_pkg::ST_TAKE;
		end
	end

	assign utx = utx_q;

	////////////////////////////////////////////////////////////////////////
	// tandem request, grant and busy

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			grant_q     <= 1'b0;
			busy_prev_q <= 1'b0;
		end
		else
		begin
			busy_prev_q <= busy_s;
			if (!is_pri || !ctrl_q.tandem)
				grant_q <= 1'b0;
			else if (st_q == tuma_pkg::ST_POLL || st_q == tuma_pkg::ST_SEL
				|| st_q == tuma_pkg::ST_XFER)
			begin
				if (req_s)
					grant_q <= 1'b1;
			end
			else if (st_q == tuma_pkg::ST_OFF)
			begin
				if (busy_s != busy_prev_q)
					grant_q <= 1'b0;
				else if (busy_s)
					grant_q <= req_s && !pick[6];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			req_q  <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			req_q  <= !is_pri && booted && pick[6] && (st_q == tuma_pkg::ST_OFF
				|| (st_q == tuma_pkg::ST_XFER
				&& cnt_q >= (words >> 1)));
			busy_q <= st_d != tuma_pkg::ST_OFF;
		end
	end

	assign tdm_req_o   = req_q;
	assign tdm_grant_o = grant_q;
	assign tdm_busy_o  = busy_q;

	////////////////////////////////////////////////////////////////////////
	// cell source outputs

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port_q <= '0;
			xfer_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			if (st_d == tuma_pkg::ST_SEL)
				port_q <= pick[5:0];
			xfer_q <= st_d == tuma_pkg::ST_XFER;
			done_q <= st_q == tuma_pkg::ST_XFER && cnt_q == words - 6'h01;
		end
	end

	assign cell_port_o     = port_q;
	assign cell_xfer_o     = xfer_q;
	assign cell_done_o     = done_q;
	assign rx_accept_all_o = ctrl_q.tandem;

	////////////////////////////////////////////////////////////////////////
	// axi4-lite slave

	logic                      aw_q;
	logic                      w_q;
	logic [3:0]                awaddr_q;
	logic [31:0]               wdata_q;
	logic [3:0]                wstrb_q;
	logic [31:0]               wmerge;
	tuma_pkg::tuma_stat_t      stat;

	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_comb
	begin
		wmerge = 32'(ctrl_q);
		for (int b = 0; b < 4; b++)
		begin
			if (wstrb_q[b])
				wmerge[b*8 +: 8] = wdata_q[b*8 +: 8];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q         <= 1'b0;
			w_q          <= 1'b0;
			awaddr_q     <= '0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= tuma_pkg::RESP_OKAY;
			ctrl_q       <= tuma_pkg::CTRL_RST;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q     <= 1'b1;
				awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (aw_q && w_q)
			begin
				aw_q         <= 1'b0;
				w_q          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= tuma_pkg::RESP_OKAY;
				if (awaddr_q == tuma_pkg::REG_CTRL)
					ctrl_q <= tuma_pkg::tuma_ctrl_t'(wmerge[tuma_pkg::CTRL_W-1:0]);
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	assign stat = '{last_addr: addr_s, slave: ctrl_q.slave,
		xfer: xfer_q, req: req_q, grant: grant_s | grant_q,
		owner: busy_q, primary: is_pri};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= tuma_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= tuma_pkg::RESP_OKAY;
			unique case ({s_axi_araddr[3:2], 2'b00})
				tuma_pkg::REG_CTRL: s_axi_rdata <= 32'(ctrl_q);
				tuma_pkg::REG_STAT: s_axi_rdata <= 32'(stat);
				tuma_pkg::REG_VPI:
					s_axi_rdata <= 32'(ctrl_q.nni ? tuma_pkg::VPI_NNI
						: tuma_pkg::VPI_UNI);
				default: s_axi_rdata <= 32'(cell_len(ctrl_q));
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			xfer_run <= '0;
		else if (st_q == tuma_pkg::ST_XFER)
			xfer_run <= xfer_run + 7'h01;
		else
			xfer_run <= '0;
	end

	sequence s_release;
		st_q == tuma_pkg::ST_REL && utx.addr == 5'h1F && utx.enb_n == 4'hF;
	endsequence

	sequence s_dead;
		!utx.addr_oe && !utx.enb_oe;
	endsequence

	a_release_high: assert property ((st_q == tuma_pkg::ST_REL) |-> s_release)
		else $error("release cycle not driven high");
	a_dead_after: assert property ((st_q == tuma_pkg::ST_REL) |=> s_dead)
		else $error("bus driven in dead cycle");
	a_float_off: assert property ((st_q == tuma_pkg::ST_OFF) |-> s_dead)
		else $error("outputs driven while peer owns bus");
	a_one_select: assert property ($onehot0(~utx.enb_n)
		&& (st_q == tuma_pkg::ST_XFER) == (utx.enb_n != 4'hF))
		else $error("enable pattern wrong");
	a_grant_req: assert property ((is_pri && ctrl_q.tandem && req_s
		&& st_q == tuma_pkg::ST_XFER) |=> grant_q)
		else $error("request not granted");
	a_keep_bus: assert property ((is_pri && !grant_q
		&& st_q == tuma_pkg::ST_XFER && cnt_q == words - 6'h01)
		|=> st_q == tuma_pkg::ST_POLL)
		else $error("primary left bus without grant");
	a_xfer_len: assert property ((st_q != tuma_pkg::ST_XFER
		&& $past(st_q) == tuma_pkg::ST_XFER)
		|-> $past(xfer_run) == {1'b0, words} - 7'h01)
		else $error("cell length wrong");
	a_sec_req: assert property ((!is_pri && booted && pick[6]
		&& st_q == tuma_pkg::ST_OFF) |=> req_q)
		else $error("secondary did not request");
	a_resume_addr: assert property ((st_d == tuma_pkg::ST_TAKE)
		|=> poll_q == next_addr($past(seen_q), ctrl_q.poll_max))
		else $error("polling did not resume");
	a_slave_quiet: assert property (ctrl_q.slave |=> !utx.addr_oe)
		else $error("slave mode drove pins");

endmodule

/* File: tuma_phy_model.sv */
// Purpose: phys and shared pins on the far side of the arbiter
// Assumes: clav answers the address on the bus in the same cycle
// Notes:   flags any cycle in which both masters drive at once
`timescale 1ns/1ps
////////////////////////////////////////
module tuma_phy_model
(
	// clock
	input  wire logic                aclk,
	// both masters
	input  wire tuma_pkg::tuma_utx_t utx,
	input  wire logic                peer_oe,
	input  wire logic [4:0]          peer_addr,
	// cell space, bit = pair*16 + addr
	input  wire logic [63:0]         clav_map,
	// resolved lines
	output      logic [4:0]          bus_addr,
	output      logic [3:0]          clav,
	output      logic                clash
);
////////////////////////////////////////
	// pull-ups hold the line high when nobody drives
	always_comb
	begin
		bus_addr = 5'h1F;
		if (utx.addr_oe)
			bus_addr = utx.addr;
		else if (peer_oe)
			bus_addr = peer_addr;
	end

	// one phy per pair on each of 16 addresses, no wrap
	always_comb
	begin
		for (int p = 0; p < 4; p++)
			clav[p] = !bus_addr[4] && clav_map[{p[1:0], bus_addr[3:0]}];
	end

	logic both_q = 1'b0;

	always @(posedge aclk)
		if ((utx.addr_oe || utx.enb_oe) && peer_oe)
			both_q <= 1'b1;

	assign clash = both_q;
endmodule

/* File: test_tandem_utopia_master_arbiter.sv */
// Purpose: register, cell and tandem handover checks for the arbiter
// Assumes: bench plays the peer master through the phy model
// Notes:   standalone, primary and secondary roles in turn
`timescale 1ns/1ps
////////////////////////////////////////
module test_tandem_utopia_master_arbiter;
	logic                       aclk = 1'b0;
	logic                       aresetn = 1'b0;
	logic [tuma_pkg::AXI_AW-1:0] awaddr = '0;
	logic [tuma_pkg::AXI_AW-1:0] araddr = '0;
	logic [31:0]                wdata = 32'h0;
	logic [3:0]                 wstrb = 4'h0;
	logic                       awvalid = 1'b0;
	logic                       wvalid = 1'b0;
	logic                       bready = 1'b0;
	logic                       arvalid = 1'b0;
	logic                       rready = 1'b0;
	logic                       awready, wready, bvalid, arready, rvalid;
	logic [31:0]                rdata, v;
	tuma_pkg::tuma_utx_t        utx;
	logic [4:0]                 bus_addr;
	logic [4:0]                 peer_addr = 5'h1F;
	logic [3:0]                 clav;
	logic                       peer_oe = 1'b0;
	logic                       req_i = 1'b0;
	logic                       grant_i = 1'b0;
	logic                       busy_i = 1'b0;
	logic                       strap = 1'b1;
	logic                       clash, req_o, grant_o, busy_o, done, acc;
	logic                       xfer;
	logic [1:0]                 bresp, rresp;
	logic [63:0]                pend = 64'h0;
	logic [63:0]                clav_map = 64'h0;
	logic [5:0]                 port;
	int                         fails = 0;
	int                         n_compared = 0;
	int                         k;

	tuma_arbiter DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .utx(utx),
		.utx_addr_i(bus_addr), .utx_clav_i(clav), .tdm_req_o(req_o),
		.tdm_grant_o(grant_o), .tdm_busy_o(busy_o), .tdm_req_i(req_i),
		.tdm_grant_i(grant_i), .tdm_busy_i(busy_i),
		.strap_primary_i(strap), .cell_pend_i(pend), .cell_port_o(port),
		.cell_xfer_o(xfer), .cell_done_o(done), .rx_accept_all_o(acc));

	tuma_phy_model phys (.aclk(aclk), .utx(utx), .peer_oe(peer_oe),
		.peer_addr(peer_addr), .clav_map(clav_map), .bus_addr(bus_addr),
		.clav(clav), .clash(clash));
////////////////////////////////////////
	initial
	begin
		forever #20 aclk = ~aclk;
	end

	task automatic test_done;
		if (fails == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		v = rdata;
		rready <= 1'b0;
	endtask

	task automatic rst(input logic prim);
		@(posedge aclk);
		aresetn <= 1'b0;
		strap <= prim;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	// enable cycles of one cell, up to its done pulse
	task automatic cell_run(output int cnt, output int bad,
		output logic [5:0] p);
		int t;
		cnt = 0;
		bad = 0;
		p = 6'h0;
		t = 0;
		while (done !== 1'b1 && t < 400)
		begin
			@(posedge aclk);
			t++;
			if (utx.enb_oe && utx.enb_n !== 4'hF)
			begin
				cnt++;
				p = port;
				// source drops its pending flag once the cell is taken
				pend <= 64'h0;
				if (utx.enb_n !== 4'hB)
					bad++;
			end
			if (xfer !== (utx.enb_n !== 4'hF))
				bad++;
		end
	endtask

	task automatic wait_oe;
		int t;
		t = 0;
		while (utx.addr_oe !== 1'b1 && t < 100)
		begin
			@(posedge aclk);
			t++;
		end
	endtask

	// bench as peer master hands the bus back
	task automatic peer_release;
		@(posedge aclk);
		peer_addr <= 5'h1F;
		@(posedge aclk);
		peer_oe <= 1'b0;
		@(posedge aclk);
		busy_i <= 1'b0;
	endtask
////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge aclk);
		fails++;
		test_done;
	end

	initial
	begin
		int cnt;
		int bad;
		logic [5:0] p;
		rst(1'b1);
		rd(tuma_pkg::REG_CTRL);
		chk(v, 32'h1E0);
		wr(tuma_pkg::REG_LEN, 32'h0);
		rd(tuma_pkg::REG_LEN);
		chk(v, 32'h35);
		chk({28'h0, bresp, rresp}, 32'h0);
		for (k = 0; k < 4; k++)
		begin
			wr(tuma_pkg::REG_CTRL, {22'h0, 5'h0F, k[0], k[1], k[0], 2'b00});
			rd(tuma_pkg::REG_LEN);
			chk(v, 32'h35 + {29'h0, k[1], 1'b0, k[0]});
			rd(tuma_pkg::REG_VPI);
			chk(v, k[0] ? 32'h1000 : 32'h100);
		end
		wr(tuma_pkg::REG_CTRL, 32'h1E2);
		repeat (4) @(posedge aclk);
		chk(utx.addr_oe, 1'b0);
		// standalone primary sends one cell to pair 2, address 3
		wr(tuma_pkg::REG_CTRL, 32'h1E0);
		clav_map[35] <= 1'b1;
		pend[35] <= 1'b1;
		cell_run(cnt, bad, p);
		pend[35] <= 1'b0;
		chk(cnt, 53);
		chk(bad, 0);
		chk(p, 6'd35);
		chk(grant_o, 1'b0);
		chk(acc, 1'b0);
		rd(tuma_pkg::REG_STAT);
		chk(v & 32'h3F, 32'h03);
		// tandem primary grants the bench peer
		wr(tuma_pkg::REG_CTRL, 32'h1E1);
		req_i <= 1'b1;
		k = 0;
		while (grant_o !== 1'b1 && k < 100)
		begin
			@(posedge aclk);
			k++;
		end
		chk(grant_o, 1'b1);
		chk(acc, 1'b1);
		bad = 0;
		while (busy_o !== 1'b0 && k < 300)
		begin
			@(posedge aclk);
			k++;
			if (utx.addr_oe && utx.addr === 5'h1F && utx.enb_n === 4'hF)
				bad++;
		end
		chk(bad > 0, 1'b1);
		@(posedge aclk);
		chk(bus_addr, 5'h1F);
		busy_i <= 1'b1;
		peer_oe <= 1'b1;
		peer_addr <= 5'h07;
		repeat (12) @(posedge aclk);
		chk(grant_o, 1'b1);
		req_i <= 1'b0;
		repeat (12) @(posedge aclk);
		chk(grant_o, 1'b0);
		peer_release;
		wait_oe;
		chk(utx.addr, 5'h08);
		// secondary role with the bench polling as primary
		rst(1'b0);
		peer_oe <= 1'b1;
		busy_i <= 1'b1;
		wr(tuma_pkg::REG_CTRL, 32'h1E1);
		pend[35] <= 1'b1;
		for (k = 0; k < 43; k++)
		begin
			@(posedge aclk);
			peer_addr <= {1'b0, k[3:0]};
		end
		repeat (4) @(posedge aclk);
		chk(req_o, 1'b1);
		grant_i <= 1'b1;
		peer_release;
		wait_oe;
		chk(utx.addr, 5'h0B);
		chk(busy_o, 1'b1);
		grant_i <= 1'b0;
		cell_run(cnt, bad, p);
		chk(cnt, 53);
		chk(bad, 0);
		chk(p, 6'd35);
		chk(clash, 1'b0);
		test_done;
	end
endmodule
